//--- rsl_defs.svh
// Constants of the reset strap latch: register offsets, field positions,
// reset values. Assumes inclusion by the package and the design modules.
//
// Operation
// - Sample each strap as reset is released; hold it until a software write or the next reset.
// - Software reads and overwrites every latched strap at offset 48.
// - Address and chip-select straps live read-write in bits 9 to 6.
// - Address and chip-select straps mirror into keyboard port bits 16, 15, 14 and 13; the keyboard select strap drives kbc_internal_en.
// - Keyboard select strap high picks internal, low picks external.
// - Write-one-clear bits clear on a written 1; a 0 leaves them.
// - Reserved register bits read back as zero.
`ifndef RSL_DEFS_SVH
`define RSL_DEFS_SVH

`define RSL_ADDR_W        8
`define RSL_STRAP_OFS     8'h48
`define RSL_STATUS_OFS    8'h4C
`define RSL_ADDR_LSB      6
`define RSL_ADDR_MSB      8
`define RSL_CS_BIT        9
`define RSL_KBC_BIT       10
`define RSL_STRAP_MASK    16'h07C0
`define RSL_STRAP_RST     16'h0000
`define RSL_KBP_ADDR2     16
`define RSL_KBP_ADDR1     15
`define RSL_KBP_ADDR0     14
`define RSL_KBP_CS        13
`define RSL_ST_CHANGED    0
`define RSL_ST_MASK       16'h0001

`endif

//--- rsl_pkg.sv
// Types of the reset strap latch.
// Assumes the constants header sits in the same folder.
`include "rsl_defs.svh"

package rsl_pkg;
   typedef enum logic [1:0] {RSL_IN_RESET, RSL_CAPTURE, RSL_RUN} rsl_state_e;
   typedef logic [15:0] rsl_word_t;
endpackage : rsl_pkg

//--- rsl_sync.sv
// Two-flop synchroniser for one strap pin.
// Assumes the pin is static around reset release; no metastability filter.
`timescale 1ns/100ps

module rsl_sync
(
   // Clock and enable.
   input  wire logic core_clk,
   input  wire logic clk_en,
   // Pin in, level out.
   input  wire logic pin_in,
   output logic      level_out
);
   logic meta_reg;

   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         meta_reg  <= pin_in;
         level_out <= meta_reg;
      end
   end
endmodule : rsl_sync

//--- rsl_strap_latch.sv
// Reset strap latch: captures straps at power-good release, exposes them
// in a software register and mirrors them to the keyboard controller.
// Assumes straps are static pins and the register port is on core_clk.
`timescale 1ns/100ps
`include "rsl_defs.svh"

module rsl_strap_latch
   import rsl_pkg::*;
#(
   parameter int NUM_ADDR = 3
)
(
   // Clock, reset, enable.
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   // Strap pins.
   input  wire logic [NUM_ADDR-1:0]    strap_addr,
   input  wire logic                   strap_chip_select_n,
   input  wire logic                   kbc_internal_select_strap,
   // Register port.
   input  wire logic [`RSL_ADDR_W-1:0] reg_addr,
   input  wire logic [15:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [15:0]            reg_rdata,
   // Keyboard controller side.
   output logic      [16:13]           kbc_port_bits,
   output logic                        kbc_internal_en,
   output logic                        strap_valid
);
   localparam int NPIN = NUM_ADDR + 2;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_sync;
   rsl_state_e      state_reg;
   rsl_word_t       strap_reg;
   logic            changed_reg;
   logic            wr_strap;
   logic            wr_status;
   rsl_word_t       strap_next;

   assign pin_raw = {kbc_internal_select_strap, strap_chip_select_n,
                     strap_addr};

   // One synchroniser per strap pin.
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         rsl_sync u_sync
         (
            .core_clk  (core_clk),
            .clk_en    (clk_en),
            .pin_in    (pin_raw[gi]),
            .level_out (pin_sync[gi])
         );
      end
   endgenerate

   assign wr_strap  = reg_wr && (reg_addr == `RSL_STRAP_OFS);
   assign wr_status = reg_wr && (reg_addr == `RSL_STATUS_OFS);

   // Capture waits one extra cycle after release so the synchronisers
   // hold the pin level rather than a value taken during reset.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         state_reg <= RSL_IN_RESET;
      else if (clk_en)
      begin
         case (state_reg)
            RSL_IN_RESET: state_reg <= RSL_CAPTURE;
            RSL_CAPTURE:  state_reg <= RSL_RUN;
            RSL_RUN:      state_reg <= RSL_RUN;
            default:      state_reg <= RSL_IN_RESET;
         endcase
      end
   end

   always_comb
   begin
      strap_next = strap_reg;
      strap_next[`RSL_ADDR_MSB:`RSL_ADDR_LSB] = pin_sync[NUM_ADDR-1:0];
      strap_next[`RSL_CS_BIT]  = pin_sync[NUM_ADDR];
      strap_next[`RSL_KBC_BIT] = pin_sync[NUM_ADDR+1];
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         strap_reg <= `RSL_STRAP_RST;
      else if (clk_en)
      begin
         if (state_reg == RSL_CAPTURE)
            strap_reg <= strap_next;
         else if (wr_strap && state_reg == RSL_RUN)
            strap_reg <= reg_wdata & `RSL_STRAP_MASK;
      end
   end

   // Sticky flag: set when software overrode a strap, cleared by a 1.
   always_ff @(posedge core_clk)
   begin
      if (rst)
         changed_reg <= 1'b0;
      else if (clk_en)
      begin
         if (wr_strap && state_reg == RSL_RUN)
            changed_reg <= 1'b1;
         else if (wr_status && reg_wdata[`RSL_ST_CHANGED])
            changed_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (clk_en)
      begin
         if (reg_rd && reg_addr == `RSL_STRAP_OFS)
            reg_rdata <= strap_reg & `RSL_STRAP_MASK;
         else if (reg_rd && reg_addr == `RSL_STATUS_OFS)
            reg_rdata <= {15'h0000, changed_reg};
         else
            reg_rdata <= 16'h0000;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         kbc_port_bits   <= 4'h0;
         kbc_internal_en <= 1'b0;
         strap_valid     <= 1'b0;
      end
      else if (clk_en)
      begin
         kbc_port_bits[`RSL_KBP_ADDR2] <= strap_reg[`RSL_ADDR_LSB+2];
         kbc_port_bits[`RSL_KBP_ADDR1] <= strap_reg[`RSL_ADDR_LSB+1];
         kbc_port_bits[`RSL_KBP_ADDR0] <= strap_reg[`RSL_ADDR_LSB];
         kbc_port_bits[`RSL_KBP_CS]    <= strap_reg[`RSL_CS_BIT];
         kbc_internal_en <= strap_reg[`RSL_KBC_BIT];
         strap_valid     <= (state_reg == RSL_RUN);
      end
   end
endmodule : rsl_strap_latch

//--- rsl_strap_latch_checker.sv
// Port checker for the strap latch.
// Assumes it is bound to the latch; clock core_clk, reset rst.
`timescale 1ns/100ps
`include "rsl_defs.svh"
module rsl_strap_latch_checker #(parameter int NUM_ADDR = 3)
(
   // Clock, reset and straps.
   input wire logic core_clk, rst, strap_chip_select_n,
   input wire logic kbc_internal_select_strap,
   input wire logic [NUM_ADDR-1:0] strap_addr,
   // Register port and mirrors.
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata, reg_rdata,
   input wire logic reg_wr, reg_rd, kbc_internal_en, strap_valid,
   input wire logic [16:13] kbc_port_bits
);
   wire [4:0] wm = {reg_wdata[10], reg_wdata[8:6], reg_wdata[9]};
   wire [4:0] rm = {reg_rdata[10], reg_rdata[8:6], reg_rdata[9]};
   wire [4:0] mir = {kbc_internal_en, kbc_port_bits};
   wire rd48 = reg_rd && reg_addr == 8'h48;
   wire wr48 = reg_wr && reg_addr == 8'h48;
   wire rdx = reg_rd && reg_addr != 8'h48 && reg_addr != 8'h4C;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
      else $error("read data not zero when idle");
   rsvd_zero_a: assert property ($past(rd48) |->
      (reg_rdata & ~`RSL_STRAP_MASK) == 0) else $error("reserved bit set");
   unmapped_a: assert property ($past(rdx) |-> reg_rdata == 0)
      else $error("unmapped read not zero");
   mirror_a: assert property (strap_valid && $past(rd48) |-> mir == rm)
      else $error("mirror differs from register");
   capture_a: assert property ($rose(strap_valid) |-> mir ==
      {kbc_internal_select_strap, strap_addr, strap_chip_select_n})
      else $error("captured straps wrong");
   hold_a: assert property ($past(strap_valid) && !$past(reg_wr, 2)
      |-> $stable(mir)) else $error("mirror changed without write");
   wr_mirror_a: assert property ($past(strap_valid, 2) && $past(wr48, 2)
      |-> mir == $past(wm, 2)) else $error("write not mirrored");
   wr_read_a: assert property ($past(strap_valid, 2) && $past(wr48, 2)
      && $past(rd48) |-> reg_rdata == ($past(reg_wdata, 2) & 16'h07C0))
      else $error("written value not read back");
endmodule : rsl_strap_latch_checker
bind rsl_strap_latch rsl_strap_latch_checker #(.NUM_ADDR(NUM_ADDR)) chk_i
   (.core_clk, .rst, .strap_chip_select_n, .kbc_internal_select_strap,
    .strap_addr, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr, .reg_rd,
    .kbc_internal_en, .strap_valid, .kbc_port_bits);

//--- rsl_board.sv
// Board strap resistors driving the strap pins.
// Assumes the bench picks the pull levels; a pulled pin never floats.
`timescale 1ns/100ps
module rsl_board
(
   // Pull levels and pins.
   input  wire logic [4:0] pulls,
   output logic      [2:0] strap_addr,
   output logic            strap_chip_select_n,
   output logic            kbc_internal_select_strap
);
   assign {kbc_internal_select_strap, strap_chip_select_n, strap_addr} =
      pulls;
endmodule : rsl_board

//--- rsl_strap_latch_tb.sv
// Bench for the strap latch: two resets, register traffic, mirrors.
// Assumes the checker binds itself to the latch.
`timescale 1ns/100ps
`include "rsl_defs.svh"
`define CHK(n, e, a) samples_checked++; if ((a) !== (e)) begin \
   num_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end
module rsl_strap_latch_tb import rsl_pkg::*;;
   logic core_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
   logic [7:0] reg_addr = 0;
   logic [4:0] pulls = 0, s;
   logic [2:0] strap_addr;
   logic [16:13] kbc_port_bits;
   logic strap_chip_select_n, kbc_internal_select_strap;
   logic kbc_internal_en, strap_valid;
   rsl_word_t reg_wdata = 0, reg_rdata, got, w, exp_q[$];
   int num_errors = 0, samples_checked = 0;
   rsl_board rsl_board_i (.pulls, .strap_addr, .strap_chip_select_n,
      .kbc_internal_select_strap);
   rsl_strap_latch rsl_strap_latch_i (.core_clk, .rst, .clk_en, .strap_addr,
      .strap_chip_select_n, .kbc_internal_select_strap, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .kbc_port_bits, .kbc_internal_en,
      .strap_valid);
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) rd_d <= reg_rd;
   always @(negedge core_clk)
      if (rd_d)
      begin
         got = exp_q.pop_front();
         `CHK("reg_rdata", got, reg_rdata)
      end
   task op(input logic wr, rd, input logic [7:0] a, input rsl_word_t d, e);
      reg_wr <= wr;
      reg_rd <= rd;
      reg_addr <= a;
      reg_wdata <= d;
      if (rd) exp_q.push_back(e);
      @(posedge core_clk);
   endtask : op
   task stop_test;
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      void'($urandom(32'hbd4e));
      for (int k = 0; k < 2; k++)
      begin
         s = 5'($urandom);
         pulls <= s;
         rst <= 1;
         repeat (20) @(posedge core_clk);
         rst <= 0;
         // Too early: the latch must drop this write.
         op(1, 0, 8'h48, 16'h07C0, 0);
         op(0, 0, 0, 0, 0);
         // Outputs are looked at on the falling edge, once they have settled.
         for (int i = 0; i < 8; i++)
         begin
            @(negedge core_clk);
            if (strap_valid === 1'b1)
               break;
            @(posedge core_clk);
         end
         `CHK("strap_valid", 1'b1, strap_valid)
         if (strap_valid !== 1'b1) stop_test();
         @(posedge core_clk);
         pulls <= ~s;
         op(0, 1, 8'h4C, 0, 16'h0000);
         op(0, 1, 8'h48, 0, {5'h00, s, 6'h00});
         w = 16'($urandom);
         op(1, 0, 8'h48, w, 0);
         op(0, 1, 8'h48, 0, w & `RSL_STRAP_MASK);
         op(1, 0, 8'h4C, 16'hFFFE, 0);
         op(0, 1, 8'h4C, 0, 16'h0001);
         op(1, 0, 8'h4C, 16'h0001, 0);
         op(0, 1, 8'h4C, 0, 16'h0000);
         op(0, 1, 8'h50, 0, 16'h0000);
         op(0, 0, 0, 0, 0);
         @(negedge core_clk);
         `CHK("kbc_port_bits", {w[8:6], w[9]}, kbc_port_bits)
         `CHK("kbc_internal_en", w[10], kbc_internal_en)
         @(posedge core_clk);
      end
      stop_test();
   end
endmodule : rsl_strap_latch_tb
